// file: shared/rpca_map.svh
`ifndef RPCA_MAP_SVH
`define RPCA_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define RPCA_OFS_CTRL 8'h00
`define RPCA_OFS_BUSNUM 8'h04
`define RPCA_OFS_REQID 8'h08
`define RPCA_OFS_BAR_BASE 8'h0C
`define RPCA_OFS_BAR_MASK 8'h10
`define RPCA_OFS_AXI_BASE 8'h14
`define RPCA_OFS_STATUS 8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define RPCA_CTRL_BME 0
`define RPCA_CTRL_BAR_EN 1
`define RPCA_CTRL_XLAT_EN 2
`define RPCA_BUS_PRI_LSB 0
`define RPCA_BUS_SEC_LSB 8
`define RPCA_BUS_SUB_LSB 16
`define RPCA_STAT_TIMEOUT 0
`define RPCA_STAT_BUSY 1
`define RPCA_STAT_PLM_PEND 2

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define RPCA_RST_BAR_BASE 32'h0000_0000
`define RPCA_RST_BAR_MASK 32'hFFFF_0000
`define RPCA_RST_AXI_BASE 32'h0000_0000
`define RPCA_RESP_OKAY 2'h0
`define RPCA_RESP_SLVERR 2'h2
`define RPCA_ALL_ONES 32'hFFFF_FFFF
`define RPCA_ZERO32 32'h0000_0000

// ----------------------------------------
// timing and fifo depth
// ----------------------------------------
`define RPCA_CLK_MHZ 250
`define RPCA_CFG_TIMEOUT_US 50
`define RPCA_FIFO_DEPTH 16

`endif

// file: shared/rpca_pkg.sv
package rpca_pkg;

    typedef enum logic [4:0] {
        RPCA_IDLE = 5'b00001,
        RPCA_LOCAL = 5'b00010,
        RPCA_LREQ = 5'b00100,
        RPCA_LWAIT = 5'b01000,
        RPCA_RESP = 5'b10000
    } rpca_state_t;

    typedef struct packed {
        logic wr;
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] fn;
        logic [9:0] regn;
        logic [31:0] wdata;
    } rpca_ecam_req_t;

    typedef struct packed {
        logic type1;
        logic wr;
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] fn;
        logic [9:0] regn;
        logic [31:0] wdata;
        logic [15:0] req_id;
    } rpca_cfg_tx_t;

    typedef struct packed {
        logic [1:0] resp;
        logic [31:0] rdata;
    } rpca_rsp_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } rpca_tlp_t;

endpackage

// file: verilog/rpca_root_bridge.sv
// How it works
// R1: setting bus-master enable sends one power limit message on its own.
// R2: software programs requester id before setting bus-master enable.
// R3: access to primary bus goes to local config port, never to link.
// R4: bus equal to secondary becomes a type 0 config request.
// R5: bus above secondary up to subordinate becomes a type 1 request.
// R6: software keeps primary, secondary and subordinate bus numbers current.
// R7: bus outside the range sends nothing and answers slverr.
// R8: config read answered unsupported returns all ones.
// R9: config write answered unsupported answers slverr.
// R10: software avoids config writes to absent devices.
// R11: received packets are never filtered, all go to the user side.
// R12: with no bar enabled packets pass untranslated.
// R13: bar base resets to zero until programmed.
// R14: packets hitting an enabled bar are translated before forwarding.
// R15: partner sends nothing outside the bar while it is enabled.
// R16: a timer ends each unanswered config request sent to the link with slverr; local config requests are not timed.
// R17: each config timeout also raises an interrupt pulse.
// R18: timeout length is a parameter; timer restarts per request.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "rpca_map.svh"

// ----------------------------------------
// fifo
// ----------------------------------------
module rpca_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = `RPCA_FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic full_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_chk
        $error("fifo depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } rpca_fifo_st_t;

    rpca_fifo_st_t q, d;
    logic empty;
    logic full;

    assign empty = (q.wp == q.rp);
    assign full = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = q.mem[q.rp[AW-1:0]];
    assign full_o = full;

    always_comb
    begin
        d = q;
        if (in_valid_i && !full)
        begin
            d.mem[q.wp[AW-1:0]] = in_data_i;
            d.wp = q.wp + 1'b1;
        end
        if (out_ready_i && !empty) d.rp = q.rp + 1'b1;
    end

    always_ff @(posedge clock_i)
        q <= srst_i ? '0 : d;
endmodule

// ----------------------------------------
// root side configuration access bridge
// ----------------------------------------
module rpca_root_bridge #(
    parameter int CFG_TIMEOUT_CYC = `RPCA_CFG_TIMEOUT_US * `RPCA_CLK_MHZ, // R18
    parameter int FIFO_DEPTH = `RPCA_FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic ecam_req_valid_i,
    output logic ecam_req_ready_o,
    input wire rpca_pkg::rpca_ecam_req_t ecam_req_i,
    output logic ecam_rsp_valid_o,
    input wire logic ecam_rsp_ready_i,
    output rpca_pkg::rpca_rsp_t ecam_rsp_o,
    output logic loc_cfg_valid_o,
    output rpca_pkg::rpca_ecam_req_t loc_cfg_o,
    input wire logic loc_cfg_done_i,
    input wire logic [31:0] loc_cfg_rdata_i,
    output logic cfg_tx_valid_o,
    input wire logic cfg_tx_ready_i,
    output rpca_pkg::rpca_cfg_tx_t cfg_tx_o,
    input wire logic cpl_valid_i,
    input wire logic cpl_ur_i,
    input wire logic [31:0] cpl_data_i,
    output logic plm_valid_o,
    input wire logic plm_ready_i,
    output logic [15:0] plm_req_id_o,
    output logic cfg_timeout_irq_o,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    input wire rpca_pkg::rpca_tlp_t rx_tlp_i,
    output logic user_valid_o,
    input wire logic user_ready_i,
    output rpca_pkg::rpca_tlp_t user_tlp_o
);
    if (CFG_TIMEOUT_CYC < 2)
    begin : g_chk
        $error("config timeout must be at least 2 cycles");
    end

    typedef struct packed {
        rpca_pkg::rpca_state_t st;
        logic bme;
        logic bar_en;
        logic xlat_en;
        logic [7:0] pri;
        logic [7:0] sec;
        logic [7:0] sub;
        logic [15:0] req_id;
        logic [31:0] bar_base;
        logic [31:0] bar_mask;
        logic [31:0] axi_base;
        logic to_flag;
        logic plm_pend;
        logic irq;
        logic [31:0] tmr;
        rpca_pkg::rpca_ecam_req_t req;
        logic type1;
        rpca_pkg::rpca_rsp_t rsp;
        logic [31:0] rdata;
    } rpca_st_t;

    rpca_st_t q, d;
    rpca_pkg::rpca_tlp_t xl_tlp;
    logic bar_hit;
    logic [31:0] new_ctrl;

    // ----------------------------------------
    // receive path: no filtering, optional translation
    // ----------------------------------------
    assign bar_hit = q.bar_en && ((rx_tlp_i.addr & q.bar_mask) == q.bar_base);

    always_comb
    begin
        xl_tlp = rx_tlp_i; // R11 R12
        if (bar_hit && q.xlat_en)
        begin
            xl_tlp.addr = q.axi_base | (rx_tlp_i.addr & ~q.bar_mask); // R14
        end
    end

    rpca_fifo #(
        .WIDTH($bits(rpca_pkg::rpca_tlp_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .in_valid_i(rx_valid_i),
        .in_ready_o(rx_ready_o),
        .in_data_i(xl_tlp),
        .out_valid_o(user_valid_o),
        .out_ready_i(user_ready_i),
        .out_data_o(user_tlp_o),
        .full_o()
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata_o = q.rdata;
    assign ecam_req_ready_o = (q.st == rpca_pkg::RPCA_IDLE);
    assign ecam_rsp_valid_o = (q.st == rpca_pkg::RPCA_RESP);
    assign ecam_rsp_o = q.rsp;
    assign loc_cfg_valid_o = (q.st == rpca_pkg::RPCA_LOCAL); // R3
    assign loc_cfg_o = q.req;
    assign cfg_tx_valid_o = (q.st == rpca_pkg::RPCA_LREQ);
    assign cfg_tx_o = '{type1: q.type1, wr: q.req.wr, bus: q.req.bus, dev: q.req.dev,
                        fn: q.req.fn, regn: q.req.regn, wdata: q.req.wdata,
                        req_id: q.req_id};
    assign plm_valid_o = q.plm_pend;
    assign plm_req_id_o = q.req_id;
    assign cfg_timeout_irq_o = q.irq;
    assign new_ctrl = reg_wdata_i;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        d = q;
        d.irq = 1'b0;
        d.rdata = `RPCA_ZERO32;
        // register writes
        if (reg_wr_i)
            unique case (reg_addr_i)
                `RPCA_OFS_CTRL:
                begin
                    d.bme = new_ctrl[`RPCA_CTRL_BME];
                    d.bar_en = new_ctrl[`RPCA_CTRL_BAR_EN];
                    d.xlat_en = new_ctrl[`RPCA_CTRL_XLAT_EN];
                    if (new_ctrl[`RPCA_CTRL_BME] && !q.bme) d.plm_pend = 1'b1; // R1
                end
                `RPCA_OFS_BUSNUM:
                begin
                    d.pri = new_ctrl[`RPCA_BUS_PRI_LSB +: 8];
                    d.sec = new_ctrl[`RPCA_BUS_SEC_LSB +: 8];
                    d.sub = new_ctrl[`RPCA_BUS_SUB_LSB +: 8];
                end
                `RPCA_OFS_REQID: d.req_id = new_ctrl[15:0];
                `RPCA_OFS_BAR_BASE: d.bar_base = new_ctrl;
                `RPCA_OFS_BAR_MASK: d.bar_mask = new_ctrl;
                `RPCA_OFS_AXI_BASE: d.axi_base = new_ctrl;
                `RPCA_OFS_STATUS: d.to_flag = q.to_flag && !new_ctrl[`RPCA_STAT_TIMEOUT];
                default: ;
            endcase
        // register reads, data in the next cycle
        if (reg_rd_i)
            unique case (reg_addr_i)
                `RPCA_OFS_CTRL:
                begin
                    d.rdata[`RPCA_CTRL_BME] = q.bme;
                    d.rdata[`RPCA_CTRL_BAR_EN] = q.bar_en;
                    d.rdata[`RPCA_CTRL_XLAT_EN] = q.xlat_en;
                end
                `RPCA_OFS_BUSNUM:
                begin
                    d.rdata[`RPCA_BUS_PRI_LSB +: 8] = q.pri;
                    d.rdata[`RPCA_BUS_SEC_LSB +: 8] = q.sec;
                    d.rdata[`RPCA_BUS_SUB_LSB +: 8] = q.sub;
                end
                `RPCA_OFS_REQID: d.rdata[15:0] = q.req_id;
                `RPCA_OFS_BAR_BASE: d.rdata = q.bar_base;
                `RPCA_OFS_BAR_MASK: d.rdata = q.bar_mask;
                `RPCA_OFS_AXI_BASE: d.rdata = q.axi_base;
                `RPCA_OFS_STATUS:
                begin
                    d.rdata[`RPCA_STAT_TIMEOUT] = q.to_flag;
                    d.rdata[`RPCA_STAT_BUSY] = (q.st != rpca_pkg::RPCA_IDLE);
                    d.rdata[`RPCA_STAT_PLM_PEND] = q.plm_pend;
                end
                default: ;
            endcase
        // the message only leaves once the link side takes it
        if (q.plm_pend && plm_ready_i) d.plm_pend = 1'b0;
        // ----------------------------------------
        // configuration access sequencer
        // ----------------------------------------
        unique case (q.st)
            rpca_pkg::RPCA_IDLE:
            begin
                if (ecam_req_valid_i)
                begin
                    d.req = ecam_req_i;
                    d.type1 = (ecam_req_i.bus != q.sec); // R4 R5
                    if (ecam_req_i.bus == q.pri)
                        d.st = rpca_pkg::RPCA_LOCAL; // R3
                    else if (ecam_req_i.bus >= q.sec && ecam_req_i.bus <= q.sub)
                        d.st = rpca_pkg::RPCA_LREQ; // R4 R5
                    else
                    begin
                        d.rsp = '{resp: `RPCA_RESP_SLVERR, rdata: `RPCA_ZERO32}; // R7
                        d.st = rpca_pkg::RPCA_RESP;
                    end
                end
            end
            rpca_pkg::RPCA_LOCAL:
            begin
                if (loc_cfg_done_i)
                begin
                    d.rsp = '{resp: `RPCA_RESP_OKAY, rdata: loc_cfg_rdata_i};
                    d.st = rpca_pkg::RPCA_RESP;
                end
            end
            rpca_pkg::RPCA_LREQ:
            begin
                if (cfg_tx_ready_i)
                begin
                    d.tmr = `RPCA_ZERO32; // R18
                    d.st = rpca_pkg::RPCA_LWAIT;
                end
            end
            rpca_pkg::RPCA_LWAIT:
            begin
                d.tmr = q.tmr + 32'h0000_0001;
                if (cpl_valid_i)
                begin
                    d.st = rpca_pkg::RPCA_RESP;
                    d.rsp = '{resp: `RPCA_RESP_OKAY, rdata: `RPCA_ZERO32};
                    if (q.req.wr && cpl_ur_i) d.rsp.resp = `RPCA_RESP_SLVERR; // R9
                    if (!q.req.wr) d.rsp.rdata = cpl_ur_i ? `RPCA_ALL_ONES : cpl_data_i; // R8
                end
                else if (q.tmr == 32'(CFG_TIMEOUT_CYC - 1))
                begin
                    d.rsp = '{resp: `RPCA_RESP_SLVERR, rdata: `RPCA_ZERO32}; // R16
                    d.to_flag = 1'b1; // R17
                    d.irq = 1'b1; // R17
                    d.st = rpca_pkg::RPCA_RESP;
                end
            end
            rpca_pkg::RPCA_RESP:
            begin
                if (ecam_rsp_ready_i) d.st = rpca_pkg::RPCA_IDLE;
            end
            default: d.st = rpca_pkg::RPCA_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
        if (srst_i)
        begin
            q <= '0;
            q.st <= rpca_pkg::RPCA_IDLE;
            q.bar_base <= `RPCA_RST_BAR_BASE; // R13
            q.bar_mask <= `RPCA_RST_BAR_MASK;
            q.axi_base <= `RPCA_RST_AXI_BASE;
        end
        else
            q <= d;
endmodule

// file: bench/rpca_checker.sv
`timescale 1ns/1ps
`include "rpca_map.svh"

module rpca_checker #(
    parameter int CFG_TIMEOUT_CYC = 20
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic ecam_req_valid_i,
    input wire logic ecam_req_ready_o,
    input wire rpca_pkg::rpca_ecam_req_t ecam_req_i,
    input wire logic ecam_rsp_valid_o,
    input wire logic ecam_rsp_ready_i,
    input wire rpca_pkg::rpca_rsp_t ecam_rsp_o,
    input wire logic loc_cfg_valid_o,
    input wire rpca_pkg::rpca_ecam_req_t loc_cfg_o,
    input wire logic cfg_tx_valid_o,
    input wire logic cfg_tx_ready_i,
    input wire rpca_pkg::rpca_cfg_tx_t cfg_tx_o,
    input wire logic cpl_valid_i,
    input wire logic cpl_ur_i,
    input wire logic plm_valid_o,
    input wire logic plm_ready_i,
    input wire logic [15:0] plm_req_id_o,
    input wire logic cfg_timeout_irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    // ----------------------------------------
    // shadow of what software programmed and of the request in flight
    // ----------------------------------------
    logic [23:0] bus_q;
    logic [15:0] id_q;
    logic bme_q;
    logic wr_q;
    logic wait_q;
    int wcnt_q;
    wire logic ctrl_wr = reg_wr_i && reg_addr_i == `RPCA_OFS_CTRL;
    wire logic oor = ecam_req_i.bus != bus_q[7:0]
        && (ecam_req_i.bus < bus_q[15:8] || ecam_req_i.bus > bus_q[23:16]);
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            bus_q <= '0;
            id_q <= '0;
            bme_q <= 1'b0;
            wr_q <= 1'b0;
            wait_q <= 1'b0;
            wcnt_q <= 0;
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == `RPCA_OFS_BUSNUM)
                bus_q <= reg_wdata_i[23:0];
            if (reg_wr_i && reg_addr_i == `RPCA_OFS_REQID)
                id_q <= reg_wdata_i[15:0];
            if (ctrl_wr)
                bme_q <= reg_wdata_i[0];
            if (ecam_req_valid_i && ecam_req_ready_o)
                wr_q <= ecam_req_i.wr;
            // wait length, frozen once the answer shows
            if (cfg_tx_valid_o && cfg_tx_ready_i)
            begin
                wait_q <= 1'b1;
                wcnt_q <= 0;
            end
            else if (ecam_rsp_valid_o)
                wait_q <= 1'b0;
            else if (wait_q)
                wcnt_q <= wcnt_q + 1;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_plm_send: assert property (ctrl_wr && reg_wdata_i[0] && !bme_q |=>
        plm_valid_o && plm_req_id_o == id_q) else $error("power limit message not sent");
    a_plm_hold: assert property (plm_valid_o && !plm_ready_i |=>
        plm_valid_o && $stable(plm_req_id_o)) else $error("power limit message dropped");
    a_local_only: assert property (loc_cfg_valid_o |->
        loc_cfg_o.bus == bus_q[7:0] && !cfg_tx_valid_o) else $error("local access leaked");
    a_cfg_type: assert property (cfg_tx_valid_o |->
        cfg_tx_o.type1 == (cfg_tx_o.bus != bus_q[15:8]) && cfg_tx_o.bus >= bus_q[15:8]
        && cfg_tx_o.bus <= bus_q[23:16]) else $error("config request type wrong");
    a_range_err: assert property (ecam_req_valid_i && ecam_req_ready_o && oor |->
        ##[1:2] ecam_rsp_valid_o && ecam_rsp_o.resp == `RPCA_RESP_SLVERR)
        else $error("out of range access not refused");
    a_ur_read: assert property (cpl_valid_i && cpl_ur_i && !wr_q && wait_q |=>
        ecam_rsp_valid_o && ecam_rsp_o.rdata == `RPCA_ALL_ONES) else $error("ur read not ones");
    a_ur_write: assert property (cpl_valid_i && cpl_ur_i && wr_q && wait_q |=>
        ecam_rsp_valid_o && ecam_rsp_o.resp == `RPCA_RESP_SLVERR) else $error("ur write not err");
    a_rsp_hold: assert property (ecam_rsp_valid_o && !ecam_rsp_ready_i |=>
        ecam_rsp_valid_o && $stable(ecam_rsp_o)) else $error("response dropped");
    a_timeout_irq: assert property (cfg_timeout_irq_o |-> ecam_rsp_valid_o
        && ecam_rsp_o.resp == `RPCA_RESP_SLVERR && wcnt_q >= CFG_TIMEOUT_CYC - 1
        && wcnt_q <= CFG_TIMEOUT_CYC + 2) else $error("timeout flagged wrongly");
    a_wait_bound: assert property (wait_q |-> wcnt_q <= CFG_TIMEOUT_CYC + 4)
        else $error("config request never ended");
    c_timeout: cover property (cfg_timeout_irq_o);
    c_local: cover property (loc_cfg_valid_o);
    c_plm: cover property (plm_valid_o && plm_ready_i);
endmodule

// file: bench/rpca_link_model.sv
`timescale 1ns/1ps

module rpca_link_model (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [1:0] mode_i,
    input wire logic [3:0] delay_i,
    input wire logic cfg_tx_valid_i,
    input wire rpca_pkg::rpca_cfg_tx_t cfg_tx_i,
    output logic cfg_tx_ready_o,
    output logic cpl_valid_o,
    output logic cpl_ur_o,
    output logic [31:0] cpl_data_o,
    input wire logic plm_valid_i,
    output logic plm_ready_o
);
    logic busy_q;
    logic [3:0] cnt_q;
    logic [7:0] bus_q;
    // mode 2 swallows the request so the bridge must time out
    assign cfg_tx_ready_o = !busy_q;
    assign cpl_ur_o = (mode_i == 2'h1);
    // data off the pulse is inverted so a stale capture cannot pass
    assign cpl_data_o = cpl_valid_o ? {24'hA5A5A5, bus_q} : ~{24'hA5A5A5, bus_q};
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            bus_q <= 8'h00;
            cpl_valid_o <= 1'b0;
            plm_ready_o <= 1'b0;
        end
        else
        begin
            cpl_valid_o <= 1'b0;
            plm_ready_o <= plm_valid_i && !plm_ready_o;
            if (cfg_tx_valid_i && !busy_q)
            begin
                busy_q <= 1'b1;
                cnt_q <= delay_i;
                bus_q <= cfg_tx_i.bus;
            end
            else if (busy_q && cnt_q == 4'h0)
            begin
                busy_q <= 1'b0;
                cpl_valid_o <= (mode_i != 2'h2);
            end
            else if (busy_q)
                cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
`include "rpca_map.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end

module tb;
    typedef struct packed {
        logic wr;
        logic [7:0] bus;
        logic [1:0] mode;
        logic [1:0] resp;
        logic [31:0] data;
        logic [1:0] tx;
        logic irq;
    } rpca_row_t;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic ecam_req_valid_i = 1'b0;
    logic ecam_rsp_ready_i = 1'b0;
    logic loc_cfg_done_i = 1'b0;
    logic rx_valid_i = 1'b0;
    logic user_ready_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic [31:0] loc_cfg_rdata_i = 32'h5A5A_0001;
    rpca_pkg::rpca_ecam_req_t ecam_req_i = '0;
    rpca_pkg::rpca_tlp_t rx_tlp_i = '0;
    logic [31:0] reg_rdata_o;
    logic [31:0] cpl_data_i;
    logic [15:0] plm_req_id_o;
    logic ecam_req_ready_o, ecam_rsp_valid_o, loc_cfg_valid_o, cfg_tx_valid_o, cfg_tx_ready_i;
    logic cpl_valid_i, cpl_ur_i, plm_valid_o, plm_ready_i, cfg_timeout_irq_o;
    logic rx_ready_o, user_valid_o;
    rpca_pkg::rpca_rsp_t ecam_rsp_o;
    rpca_pkg::rpca_ecam_req_t loc_cfg_o;
    rpca_pkg::rpca_cfg_tx_t cfg_tx_o;
    rpca_pkg::rpca_tlp_t user_tlp_o;
    rpca_pkg::rpca_tlp_t exp_q[$];
    logic [1:0] mode = 2'h0;
    logic [3:0] dly = 4'h0;
    logic tx_t1 = 1'b0;
    logic [31:0] rd;
    int fail_count = 0;
    int comparisons = 0;
    int tx_n = 0;
    int k;
    // pri 00, sec 02, sub 04
    rpca_row_t rows[9] = '{
        '{1'b0, 8'h02, 2'h0, `RPCA_RESP_OKAY, 32'hA5A5_A502, 2'h1, 1'b0},
        '{1'b0, 8'h03, 2'h0, `RPCA_RESP_OKAY, 32'hA5A5_A503, 2'h2, 1'b0},
        '{1'b1, 8'h04, 2'h0, `RPCA_RESP_OKAY, 32'h0, 2'h2, 1'b0},
        '{1'b0, 8'h05, 2'h0, `RPCA_RESP_SLVERR, 32'h0, 2'h0, 1'b0},
        '{1'b1, 8'h01, 2'h0, `RPCA_RESP_SLVERR, 32'h0, 2'h0, 1'b0},
        '{1'b0, 8'h03, 2'h1, `RPCA_RESP_OKAY, `RPCA_ALL_ONES, 2'h2, 1'b0},
        '{1'b1, 8'h02, 2'h1, `RPCA_RESP_SLVERR, 32'h0, 2'h1, 1'b0},
        '{1'b0, 8'h00, 2'h0, `RPCA_RESP_OKAY, 32'h5A5A_0001, 2'h0, 1'b0},
        '{1'b0, 8'h02, 2'h2, `RPCA_RESP_SLVERR, 32'h0, 2'h1, 1'b1}
    };

    always #2 clock_i = ~clock_i;

    rpca_root_bridge #(.CFG_TIMEOUT_CYC(20)) dut (.clock_i, .srst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ecam_req_valid_i, .ecam_req_ready_o, .ecam_req_i,
        .ecam_rsp_valid_o, .ecam_rsp_ready_i, .ecam_rsp_o, .loc_cfg_valid_o, .loc_cfg_o,
        .loc_cfg_done_i, .loc_cfg_rdata_i, .cfg_tx_valid_o, .cfg_tx_ready_i, .cfg_tx_o,
        .cpl_valid_i, .cpl_ur_i, .cpl_data_i, .plm_valid_o, .plm_ready_i, .plm_req_id_o,
        .cfg_timeout_irq_o, .rx_valid_i, .rx_ready_o, .rx_tlp_i, .user_valid_o, .user_ready_i,
        .user_tlp_o);

    rpca_link_model link (.clock_i, .srst_i, .mode_i(mode), .delay_i(dly),
        .cfg_tx_valid_i(cfg_tx_valid_o), .cfg_tx_i(cfg_tx_o), .cfg_tx_ready_o(cfg_tx_ready_i),
        .cpl_valid_o(cpl_valid_i), .cpl_ur_o(cpl_ur_i), .cpl_data_o(cpl_data_i),
        .plm_valid_i(plm_valid_o), .plm_ready_o(plm_ready_i));

    always @(negedge clock_i)
    begin
        if (cfg_tx_valid_o && cfg_tx_ready_i)
        begin
            tx_n++;
            tx_t1 = cfg_tx_o.type1;
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic test_done();
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(negedge clock_i);
        d = reg_rdata_o;
    endtask
    task automatic ecam(input rpca_row_t r);
        int n0 = tx_n;
        int w = 0;
        @(posedge clock_i);
        mode <= r.mode;
        ecam_req_valid_i <= 1'b1;
        ecam_req_i <= '{r.wr, r.bus, 5'h03, 3'h0, 10'h004, 32'h1111_0000};
        // an idle bridge takes it at this edge
        @(posedge clock_i);
        ecam_req_valid_i <= 1'b0;
        @(negedge clock_i);
        while (ecam_rsp_valid_o !== 1'b1)
        begin
            if (loc_cfg_valid_o === 1'b1)
            begin
                @(posedge clock_i);
                loc_cfg_done_i <= 1'b1;
                @(posedge clock_i);
                loc_cfg_done_i <= 1'b0;
            end
            if (++w > 200)
            begin
                fail_count++;
                test_done();
            end
            @(negedge clock_i);
        end
        `CHK("resp", r.resp, ecam_rsp_o.resp)
        if (!r.wr) `CHK("rdata", r.data, ecam_rsp_o.rdata)
        `CHK("irq", r.irq, cfg_timeout_irq_o)
        `CHK("tx", r.tx, (tx_n == n0) ? 2'h0 : {tx_t1, !tx_t1})
        @(posedge clock_i);
        ecam_rsp_ready_i <= 1'b1;
        @(posedge clock_i);
        ecam_rsp_ready_i <= 1'b0;
    endtask
    task automatic rx_push(input logic [31:0] a, input logic [31:0] e);
        @(posedge clock_i);
        rx_valid_i <= 1'b1;
        rx_tlp_i <= '{a, ~a};
        @(posedge clock_i);
        rx_valid_i <= 1'b0;
        exp_q.push_back('{e, ~a});
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b0;
        reg_rd(`RPCA_OFS_BAR_BASE, rd);
        `CHK("bar_base", `RPCA_RST_BAR_BASE, rd)
        reg_rd(8'h3C, rd);
        `CHK("unmapped", 32'h0000_0000, rd)
        reg_wr(`RPCA_OFS_BUSNUM, 32'h0004_0200);
        reg_wr(`RPCA_OFS_REQID, 32'h0000_1A2B);
        reg_wr(`RPCA_OFS_CTRL, 32'h0000_0001);
        k = 0;
        do @(negedge clock_i); while (plm_valid_o !== 1'b1 && ++k < 50);
        `CHK("plm", 1'b1, plm_valid_o)
        `CHK("plm_id", 16'h1A2B, plm_req_id_o)
        foreach (rows[i])
        begin
            dly <= 4'(2 * i);
            ecam(rows[i]);
        end
        reg_rd(`RPCA_OFS_STATUS, rd);
        `CHK("timeout_flag", 1'b1, rd[`RPCA_STAT_TIMEOUT])
        reg_wr(`RPCA_OFS_STATUS, 32'h0000_0001);
        reg_rd(`RPCA_OFS_STATUS, rd);
        `CHK("timeout_clr", 1'b0, rd[`RPCA_STAT_TIMEOUT])
        rx_push(32'h0003_0040, 32'h0003_0040);
        reg_wr(`RPCA_OFS_BAR_BASE, 32'h0001_0000);
        reg_wr(`RPCA_OFS_AXI_BASE, 32'hC000_0000);
        reg_wr(`RPCA_OFS_CTRL, 32'h0000_0007);
        // hits only: the link sends no misses while the bar is on
        for (int i = 0; i < 15; i++)
            rx_push({24'h000100, 4'(i), 4'h0}, {24'hC00000, 4'(i), 4'h0});
        @(negedge clock_i);
        `CHK("rx_full", 1'b0, rx_ready_o)
        @(posedge clock_i);
        user_ready_i <= 1'b1;
        k = 0;
        while (exp_q.size() > 0 && ++k < 100)
        begin
            @(negedge clock_i);
            if (user_valid_o === 1'b1)
                `CHK("user_tlp", exp_q.pop_front(), user_tlp_o)
        end
        @(negedge clock_i);
        `CHK("drained", 1'b0, user_valid_o)
        `CHK("left", 0, exp_q.size())
        test_done();
    end
endmodule

bind rpca_root_bridge rpca_checker #(.CFG_TIMEOUT_CYC(CFG_TIMEOUT_CYC)) u_chk (.clock_i,
    .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .ecam_req_valid_i, .ecam_req_ready_o,
    .ecam_req_i, .ecam_rsp_valid_o, .ecam_rsp_ready_i, .ecam_rsp_o, .loc_cfg_valid_o,
    .loc_cfg_o, .cfg_tx_valid_o, .cfg_tx_ready_i, .cfg_tx_o, .cpl_valid_i, .cpl_ur_i,
    .plm_valid_o, .plm_ready_i, .plm_req_id_o, .cfg_timeout_irq_o);
